// *** rsc_reset_sequencer.sv ***
// Purpose: reset sequencing, reset-cause flags, APB access to them
// Assumes: all inputs synchronous to mclk; rc_tick and osc_tick
//   are one-cycle strobes per period of their oscillators
// Notes: the analog detectors and oscillators sit outside
//   brown-out reruns the start-up count in crystal modes, as power-on does
//   a pin reset does not rerun the timers; only the filter delays it
//   a watchdog reset holds the core for a single cycle, with no timers
//   hardware cause events beat a same-cycle software write
//   clk_en low stalls the bus as well, so pready stays low meanwhile
//   osc_mode codes 6 and 7 behave as non-crystal modes
//
// Chosen here: the APB interface to the registers.
`include "rsc_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module rsc_reset_sequencer
  import rsc_pkg::*;
#(
  parameter int unsigned POWERUP_TIMER_TICKS = `RSC_POWERUP_TIMER_TICKS,
  parameter int unsigned BOR_MIN_CYC = `RSC_BOR_CYC
) (
  // Clock, reset and enable
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Configuration word
  input wire rsc_cfg_s cfg,
  // Supply and oscillator monitors
  input wire logic por_detect,
  input wire logic brownout_threshold_low,
  input wire logic rc_tick,
  input wire logic osc_tick,
  // Reset and wake sources
  input wire logic external_reset_pin_n,
  input wire logic watchdog_timeout,
  input wire rsc_core_s core_ev,
  // Core control
  output logic core_reset_n,
  output logic core_hold,
  output logic wake_pulse,
  output logic fast_internal_clock_select,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  localparam int CW = 24;
  localparam logic [CW-1:0] POWERUP_TIMER_LIM = CW'(POWERUP_TIMER_TICKS);
  localparam logic [CW-1:0] BOR_LIM = CW'(BOR_MIN_CYC);
  localparam logic [CW-1:0] OST_LIM = CW'(`RSC_OST_TICKS);
  localparam logic [CW-1:0] WAKE_LIM = CW'(`RSC_WAKE_CYC);
  localparam logic [7:0] PIN_LIM = 8'(`RSC_PIN_CYC);

  ////////////////////////////////////////////////////////////////
  // Source conditioning

  logic [7:0] pin_cnt_r;
  logic [7:0] pin_cnt_nxt;
  logic [CW-1:0] bor_cnt_r;
  logic [CW-1:0] bor_cnt_nxt;
  wire pin_raw_low = !external_reset_pin_n;
  wire pin_low = (pin_cnt_r == PIN_LIM);
  wire pin_fire = pin_raw_low && (pin_cnt_r == PIN_LIM - 8'h01);
  wire bor_low = cfg.brownout_detect_enable && brownout_threshold_low;
  wire bor_hit = (bor_cnt_r == BOR_LIM);
  wire por_lost = !por_detect;

  // A low pulse shorter than the filter count never resets
  assign pin_cnt_nxt = !pin_raw_low ? 8'h00 :
                       pin_low ? pin_cnt_r :
                       pin_cnt_r + 8'h01;

  // A dip shorter than the minimum duration is ignored
  assign bor_cnt_nxt = !bor_low ? '0 :
                       bor_hit ? bor_cnt_r :
                       bor_cnt_r + 24'h000001;

  // Both filters saturate rather than wrap, so a long low stays low
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_cnt_r <= 8'h00;
      bor_cnt_r <= '0;
    end else if (clk_en) begin
      pin_cnt_r <= pin_cnt_nxt;
      bor_cnt_r <= bor_cnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Mode decode

  wire mode_crystal = (cfg.osc_mode == rsc_crystal_low_power_mode) ||
                      (cfg.osc_mode == rsc_crystal_mid_mode) ||
                      (cfg.osc_mode == rsc_crystal_high_speed_mode);
  wire mode_onchip = (cfg.osc_mode == rsc_on_chip_clock_mode);
  wire powerup_timer_on = !cfg.powerup_timer_disable;
  // Codes 6 and 7 fall through as non-crystal: no start-up count

  ////////////////////////////////////////////////////////////////
  // Sequencer

  rsc_state_e state_r;
  rsc_state_e state_nxt;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;

  wire in_powerup_timer = (state_r == rsc_st_powerup_timer);
  wire in_ost = (state_r == rsc_st_ost);
  wire in_run = (state_r == rsc_st_run);
  wire in_wake = (state_r == rsc_st_wake);

  // Power-up timer runs on RC ticks, start-up on oscillator ticks
  wire stage_tick = (in_powerup_timer && rc_tick) ||
                    (in_ost && osc_tick) ||
                    (in_wake && (mode_crystal ? osc_tick : 1'b1));
  wire [CW-1:0] stage_lim = in_powerup_timer ? POWERUP_TIMER_LIM :
                            (in_ost || mode_crystal) ? OST_LIM :
                            WAKE_LIM;
  // Compare against limit minus one so a stage lasts exactly limit ticks
  wire stage_done = stage_tick && (cnt_r == stage_lim - 24'h000001);

  // Cause decode while running
  // The asleep level separates a wake-up from a plain watchdog reset
  wire wdt_wake = in_run && core_ev.asleep && watchdog_timeout;
  wire wdt_reset = in_run && !core_ev.asleep && watchdog_timeout;
  wire pin_sleep = pin_fire && core_ev.asleep;
  wire wake_delay = mode_crystal || mode_onchip;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = stage_tick ? cnt_r + 24'h000001 : cnt_r;
    unique case (state_r)
      rsc_st_off: begin
        // Leave only once the supply is good again
        if (por_detect && !bor_low) begin
          cnt_nxt = '0;
          if (powerup_timer_on) begin
            state_nxt = rsc_st_powerup_timer;
          end else if (mode_crystal) begin
            state_nxt = rsc_st_ost;
          end else begin
            state_nxt = rsc_st_run;
          end
        end
      end
      rsc_st_powerup_timer: begin
        if (stage_done) begin
          cnt_nxt = '0;
          state_nxt = mode_crystal ? rsc_st_ost : rsc_st_run;
        end
      end
      rsc_st_ost: begin
        if (stage_done) begin
          cnt_nxt = '0;
          state_nxt = rsc_st_run;
        end
      end
      rsc_st_run: begin
        // A watchdog reset needs no state: it only drops core_reset_n
        if (wdt_wake && wake_delay) begin
          cnt_nxt = '0;
          state_nxt = rsc_st_wake;
        end
      end
      rsc_st_wake: begin
        // Clock halted; registers keep their contents meanwhile
        if (stage_done) begin
          cnt_nxt = '0;
          state_nxt = rsc_st_run;
        end
      end
      default: begin
        cnt_nxt = '0;
        state_nxt = rsc_st_off;
      end
    endcase
    // Supply loss wins over every stage and restarts the timer
    if (por_lost || bor_hit) begin
      cnt_nxt = '0;
      state_nxt = rsc_st_off;
    end
  end

  // Wake completes at once when no delay applies
  wire wake_done = (wdt_wake && !wake_delay) || (in_wake && stage_done);

  // Pin only gates the final release; the timeouts run regardless,
  // so a pin held past them starts execution as soon as it rises
  wire core_go = (in_run || in_wake) && !por_lost && !bor_hit;
  wire core_rel = core_go && !pin_low && !wdt_reset;

  // Outputs are registered so the core never sees a decode glitch
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= rsc_st_off;
      cnt_r <= '0;
      core_reset_n <= 1'b0;
      core_hold <= 1'b0;
      wake_pulse <= 1'b0;
    end else if (clk_en) begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      core_reset_n <= core_rel;
      core_hold <= (state_nxt == rsc_st_wake);
      wake_pulse <= wake_done;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Cause flags

  logic to_r;
  logic pd_r;
  logic por_r;
  logic bor_r;
  logic fast_internal_clock_select_r;
  logic to_nxt;
  logic pd_nxt;
  logic por_nxt;
  logic bor_nxt;
  logic fast_internal_clock_select_nxt;
  logic power_control_flags_wr;

  // Hardware events are applied after the write so they win
  always_comb begin
    to_nxt = to_r;
    pd_nxt = pd_r;
    por_nxt = por_r;
    bor_nxt = bor_r;
    fast_internal_clock_select_nxt = fast_internal_clock_select_r;
    if (power_control_flags_wr) begin
      bor_nxt = pwdata[`RSC_BOR_BIT];
      por_nxt = pwdata[`RSC_POR_BIT];
      fast_internal_clock_select_nxt = pwdata[`RSC_FAST_INTERNAL_CLOCK_SELECT_BIT];
    end
    // Software commands first, then the reset causes in rising priority
    if (core_ev.clear_watchdog_cmd) begin
      to_nxt = 1'b1;
      pd_nxt = 1'b1;
    end
    if (core_ev.sleep_cmd) begin
      to_nxt = 1'b1;
      pd_nxt = 1'b0;
    end
    if (pin_sleep) begin
      to_nxt = 1'b1;
      pd_nxt = 1'b0;
    end
    if (wdt_reset) begin
      to_nxt = 1'b0;
    end
    if (wdt_wake) begin
      to_nxt = 1'b0;
      pd_nxt = 1'b0;
    end
    // Only reachable with detection on, so the flag is stale otherwise
    if (bor_hit) begin
      bor_nxt = 1'b0;
    end
    if (por_lost) begin
      to_nxt = `RSC_TO_RST;
      pd_nxt = `RSC_PD_RST;
      por_nxt = `RSC_POR_RST;
      fast_internal_clock_select_nxt = `RSC_FAST_INTERNAL_CLOCK_SELECT_RST;
    end
  end

  // Power-on values of all flags but bor_r mirror what por_lost forces above
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      to_r <= `RSC_TO_RST;
      pd_r <= `RSC_PD_RST;
      por_r <= `RSC_POR_RST;
      bor_r <= `RSC_BOR_RST;
      fast_internal_clock_select_r <= `RSC_FAST_INTERNAL_CLOCK_SELECT_RST;
    end else if (clk_en) begin
      to_r <= to_nxt;
      pd_r <= pd_nxt;
      por_r <= por_nxt;
      bor_r <= bor_nxt;
      fast_internal_clock_select_r <= fast_internal_clock_select_nxt;
    end
  end

  assign fast_internal_clock_select = fast_internal_clock_select_r;

  ////////////////////////////////////////////////////////////////
  // APB slave

  logic cap_r;
  logic err_r;
  logic [31:0] rd_r;

  // Byte address is the register index times four
  wire word_ok = (paddr[1:0] == 2'b00);
  wire hit_status = word_ok && (paddr[11:2] == `RSC_STATUS_IDX);
  wire hit_power_control_flags = word_ok && (paddr[11:2] == `RSC_POWER_CONTROL_FLAGS_IDX);
  wire hit_any = hit_status || hit_power_control_flags;

  // Bits of the status word owned elsewhere read as zero here
  logic [31:0] status_word;
  logic [31:0] power_control_flags_word;

  // Fields sit at their defined positions; unimplemented bits read zero
  always_comb begin
    status_word = 32'h00000000;
    status_word[`RSC_TO_BIT] = to_r;
    status_word[`RSC_PD_BIT] = pd_r;
    power_control_flags_word = 32'h00000000;
    power_control_flags_word[`RSC_BOR_BIT] = bor_r;
    power_control_flags_word[`RSC_POR_BIT] = por_r;
    power_control_flags_word[`RSC_FAST_INTERNAL_CLOCK_SELECT_BIT] = fast_internal_clock_select_r;
  end

  wire [31:0] rd_mux = hit_status ? status_word :
                       hit_power_control_flags ? power_control_flags_word :
                       32'h00000000;

  // Data is captured once per transfer so pready never meets stale data
  wire cap_now = psel && !cap_r && clk_en;
  assign pready = psel && penable && cap_r && clk_en;
  wire done = pready;
  assign power_control_flags_wr = done && pwrite && hit_power_control_flags;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cap_r <= 1'b0;
      err_r <= 1'b0;
      rd_r <= 32'h00000000;
    end else if (clk_en) begin
      if (done) begin
        cap_r <= 1'b0;
      end else if (cap_now) begin
        cap_r <= 1'b1;
        err_r <= !hit_any;
        rd_r <= pwrite ? 32'h00000000 : rd_mux;
      end
    end
  end

  assign prdata = rd_r;
  assign pslverr = pready && err_r;

endmodule : rsc_reset_sequencer

`default_nettype wire

// *** rsc_defs.svh ***
// Purpose: constants of the reset sequencer and cause flags
// Assumes: mclk at 100 MHz
// Notes: register offsets are word indices; byte address is index * 4
`ifndef RSC_DEFS_SVH
`define RSC_DEFS_SVH

`define RSC_CLK_NS 10

// Register indices and field positions
`define RSC_STATUS_IDX 10'h003
`define RSC_POWER_CONTROL_FLAGS_IDX 10'h08e
`define RSC_TO_BIT 4
`define RSC_PD_BIT 3
`define RSC_BOR_BIT 0
`define RSC_POR_BIT 1
`define RSC_FAST_INTERNAL_CLOCK_SELECT_BIT 3

// Power-on values of the flags
`define RSC_TO_RST 1'b1
`define RSC_PD_RST 1'b1
`define RSC_POR_RST 1'b0
`define RSC_BOR_RST 1'b0
`define RSC_FAST_INTERNAL_CLOCK_SELECT_RST 1'b1

// Times in their own units, then counts
`define RSC_POWERUP_TIMER_US 72000
`define RSC_RC_TICK_NS 1000
`define RSC_OST_TICKS 1024
`define RSC_WAKE_NS 6000
`define RSC_BOR_MIN_NS 100000
`define RSC_PIN_MIN_NS 2000
`define RSC_WAKE_CYC ((`RSC_WAKE_NS + `RSC_CLK_NS - 1) / `RSC_CLK_NS)
`define RSC_PIN_CYC ((`RSC_PIN_MIN_NS + `RSC_CLK_NS - 1) / `RSC_CLK_NS)
`define RSC_BOR_CYC ((`RSC_BOR_MIN_NS + `RSC_CLK_NS - 1) / `RSC_CLK_NS)
`define RSC_POWERUP_TIMER_TICKS (`RSC_POWERUP_TIMER_US * 1000 / `RSC_RC_TICK_NS)

`endif

// *** rsc_pkg.sv ***
// Purpose: types of the reset sequencer and cause flags
// Assumes: nothing beyond the constants header
// Notes: oscillator mode codes are local choices
package rsc_pkg;

  typedef enum logic [2:0] {
    rsc_crystal_low_power_mode = 3'h0,
    rsc_crystal_mid_mode = 3'h1,
    rsc_crystal_high_speed_mode = 3'h2,
    rsc_external_clock_mode = 3'h3,
    rsc_on_chip_clock_mode = 3'h4,
    rsc_resistor_capacitor_mode = 3'h5
  } rsc_osc_mode_e;

  typedef enum logic [4:0] {
    rsc_st_off = 5'h01,
    rsc_st_powerup_timer = 5'h02,
    rsc_st_ost = 5'h04,
    rsc_st_run = 5'h08,
    rsc_st_wake = 5'h10
  } rsc_state_e;

  typedef struct packed {
    rsc_osc_mode_e osc_mode;
    logic powerup_timer_disable;
    logic brownout_detect_enable;
  } rsc_cfg_s;

  typedef struct packed {
    logic asleep;
    logic sleep_cmd;
    logic clear_watchdog_cmd;
  } rsc_core_s;

endpackage : rsc_pkg

// *** rsc_reset_sequencer_chk.sv ***
// Purpose: concurrent checks on the reset sequencer ports
// Assumes: bound to every instance of the sequencer
// Notes: glitch and wake checks assume no other reset source fires meanwhile
`timescale 1ns/100ps
`default_nettype none
module rsc_reset_sequencer_chk
  import rsc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Sources
  input wire rsc_cfg_s cfg,
  input wire logic por_detect,
  input wire logic external_reset_pin_n,
  input wire logic watchdog_timeout,
  input wire rsc_core_s core_ev,
  // Watched outputs and bus
  input wire logic core_reset_n,
  input wire logic core_hold,
  input wire logic wake_pulse,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  wire logic crystal_w = (cfg.osc_mode <= rsc_crystal_high_speed_mode);
  wire logic rc_off_w = (cfg.osc_mode == rsc_resistor_capacitor_mode) && cfg.powerup_timer_disable;
  sequence s_access;
    psel && penable && pready;
  endsequence
  sequence s_wake_end;
    wake_pulse ##1 !wake_pulse;
  endsequence
  ////////////////////////////////////////////////////////////////////////
  AST_POR_HOLD:
    assert property (!por_detect |=> !core_reset_n) else $error("core released with supply low");
  AST_POWERUP_TIMER_HOLD:
    assert property (!cfg.powerup_timer_disable && $rose(por_detect) |-> !core_reset_n [*8]) else $error("no timer hold");
  AST_RC_NO_DELAY:
    assert property (rc_off_w && external_reset_pin_n && $rose(por_detect) |-> ##[1:3] core_reset_n)
      else $error("delay in RC mode");
  AST_PIN_GLITCH:
    assert property ($fell(external_reset_pin_n) && core_reset_n && por_detect |-> core_reset_n [*8])
      else $error("pin glitch reset core");
  AST_WDT_RESET:
    assert property (watchdog_timeout && clk_en && core_reset_n && !core_ev.asleep |=> !core_reset_n ##1 core_reset_n)
      else $error("watchdog reset not one cycle");
  AST_WAKE_HOLD:
    assert property (watchdog_timeout && clk_en && core_ev.asleep && core_reset_n && crystal_w |=> core_hold)
      else $error("wake without start-up hold");
  AST_WAKE_KEEPS:
    assert property (core_hold |-> core_reset_n) else $error("registers reset during wake");
  AST_WAKE_END:
    assert property ($fell(core_hold) |-> s_wake_end) else $error("no single wake pulse");
  AST_APB_ERR:
    assert property (s_access ##0 (paddr[1:0] != 2'h0) |-> pslverr) else $error("misaligned access accepted");
  AST_APB_STATUS:
    assert property (s_access ##0 (paddr == 12'h00c) |-> !pslverr && prdata[31:5] == 27'h0)
      else $error("bad status access");
endmodule : rsc_reset_sequencer_chk
`default_nettype wire

// *** rsc_core_model.sv ***
// Purpose: core-side partner that sleeps and kicks the watchdog on request
// Assumes: requests are one-cycle strobes
// Notes: sleep state is lost on any core reset
`timescale 1ns/100ps
`default_nettype none
module rsc_core_model
  import rsc_pkg::*;
(
  // Clock
  input wire logic mclk,
  // From the sequencer
  input wire logic core_reset_n,
  input wire logic wake_pulse,
  // Requests
  input wire logic go_sleep,
  input wire logic kick_dog,
  // To the sequencer
  output var rsc_core_s core_ev
);
  logic asleep_r;
  // A sleeping core executes nothing, so it issues no commands
  assign core_ev = {asleep_r, go_sleep && !asleep_r, kick_dog && !asleep_r};
  always_ff @(posedge mclk) begin
    if (!core_reset_n || wake_pulse) begin
      asleep_r <= 1'h0;
    end else if (go_sleep) begin
      asleep_r <= 1'h1;
    end
  end
endmodule : rsc_core_model
`default_nettype wire

// *** tb_top.sv ***
// Purpose: self-checking bench for the reset sequencer and cause flags
// Assumes: timer shortened to 20 RC ticks, brown-out filter to 4 cycles
// Notes: read words are queued by the bus driver and checked by a monitor
`include "rsc_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import rsc_pkg::*;
;
  localparam int WD = 0, PIN = 1, BO = 2, POR = 3, SLP = 4, KICK = 5;
  localparam logic [11:0] ST_A = {`RSC_STATUS_IDX, 2'h0};
  localparam logic [11:0] PC_A = {`RSC_POWER_CONTROL_FLAGS_IDX, 2'h0};
  logic mclk = 1'h0, rst_n = 1'h0, rc_tick = 1'h0, osc_tick = 1'h0;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [5:0] src = 6'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic core_reset_n, core_hold, wake_pulse, pready, pslverr, fics;
  logic [32:0] exp_q[$];
  int fails = 0, checks = 0, cyc = 0;
  rsc_cfg_s cfg = '{rsc_crystal_mid_mode, 1'h0, 1'h1};
  rsc_core_s core_ev;
  wire logic watchdog_timeout = src[WD];
  wire logic external_reset_pin_n = !src[PIN];
  wire logic brownout_threshold_low = src[BO];
  wire logic por_detect = !src[POR];
  wire logic clk_en = 1'h1;
  always #5 mclk = ~mclk;
  // RC period 100 cycles, oscillator period 2 cycles
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    rc_tick <= (cyc % 100 == 0);
    osc_tick <= ~osc_tick;
  end
  rsc_reset_sequencer #(.POWERUP_TIMER_TICKS(20), .BOR_MIN_CYC(4)) dut (.mclk, .rst_n, .clk_en, .cfg, .por_detect,
    .brownout_threshold_low, .rc_tick, .osc_tick, .external_reset_pin_n, .watchdog_timeout, .core_ev,
    .core_reset_n, .core_hold, .wake_pulse, .fast_internal_clock_select(fics), .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr);
  rsc_core_model core (.mclk, .core_reset_n, .wake_pulse, .go_sleep(src[SLP]), .kick_dog(src[KICK]), .core_ev);
  ////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, input logic [32:0] e);
    int n;
    n = 0;
    @(posedge mclk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'h1;
    if (!w) begin
      exp_q.push_back(e);
    end
    @(posedge mclk);
    penable <= 1'h1;
    do @(posedge mclk); while (pready !== 1'h1 && ++n < 50);
    if (n >= 50) begin
      fails++;
      wrap_up();
    end
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic ev(input int b, input int len);
    src[b] <= 1'h1;
    repeat (len) @(posedge mclk);
    src[b] <= 1'h0;
  endtask : ev
  task automatic wait_rst(input logic v, input int lim, output int n);
    n = 0;
    while (core_reset_n !== v && n < lim) begin
      @(posedge mclk);
      n++;
    end
    if (n >= lim) begin
      fails++;
      wrap_up();
    end
  endtask : wait_rst
  // Monitor: every completed read is matched against the oldest queued word
  always @(posedge mclk) begin
    if (psel && penable && pready === 1'h1 && !pwrite) begin
      chk({pslverr, prdata}, exp_q.pop_front());
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    int n;
    int len;
    int lows;
    logic [31:0] d;
    logic [31:0] pc;
    void'($urandom(32'h6ac3));
    repeat (6) @(posedge mclk);
    rst_n <= 1'h1;
    wait_rst(1'h1, 6000, n);
    chk(33'(n >= 3900 && n < 4300), 33'h1);
    apb(ST_A, 1'h0, 32'h0, {1'h0, 32'h18});
    apb(PC_A, 1'h0, 32'h0, {1'h0, 32'h08});
    d = $urandom;
    pc = 32'h3 | (d & 32'h8);
    apb(PC_A, 1'h1, d | 32'h3, 33'h0);
    apb(ST_A, 1'h1, $urandom, 33'h0);
    apb(PC_A, 1'h0, 32'h0, {1'h0, pc});
    chk(33'(fics), 33'(pc[3]));
    apb(ST_A, 1'h0, 32'h0, {1'h0, 32'h18});
    apb(12'h100, 1'h0, 32'h0, {1'h1, 32'h0});
    apb(ST_A + 12'h1, 1'h0, 32'h0, {1'h1, 32'h0});
    ev(WD, 1);
    apb(ST_A, 1'h0, 32'h0, {1'h0, 32'h08});
    ev(KICK, 1);
    apb(ST_A, 1'h0, 32'h0, {1'h0, 32'h18});
    ev(SLP, 1);
    apb(ST_A, 1'h0, 32'h0, {1'h0, 32'h10});
    ev(WD, 1);
    n = 0;
    while (wake_pulse !== 1'h1 && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    chk(33'(n > 2000 && n < 3000), 33'h1);
    apb(ST_A, 1'h0, 32'h0, {1'h0, 32'h00});
    apb(PC_A, 1'h0, 32'h0, {1'h0, pc});
    // Pulses of 50 to 189 cycles, under the 200-cycle filter width, must leave the core running
    len = 50 + $urandom % 140;
    lows = 0;
    src[PIN] <= 1'h1;
    repeat (len + 4) begin
      @(posedge mclk);
      src[PIN] <= (len-- > 1);
      lows += 32'(!core_reset_n);
    end
    chk(33'(lows), 33'h0);
    ev(SLP, 1);
    ev(PIN, 300);
    wait_rst(1'h1, 10, n);
    apb(ST_A, 1'h0, 32'h0, {1'h0, 32'h10});
    ev(BO, 10);
    repeat (1000) @(posedge mclk);
    ev(BO, 10);
    wait_rst(1'h1, 6000, n);
    chk(33'(n >= 3900 && n < 4300), 33'h1);
    apb(PC_A, 1'h0, 32'h0, {1'h0, pc & ~32'h1});
    cfg <= '{rsc_resistor_capacitor_mode, 1'h1, 1'h1};
    ev(POR, 5);
    wait_rst(1'h1, 4, n);
    apb(ST_A, 1'h0, 32'h0, {1'h0, 32'h18});
    chk(33'(fics), 33'h1);
    apb(PC_A, 1'h0, 32'h0, {1'h0, 32'h08});
    cfg <= '{rsc_crystal_mid_mode, 1'h0, 1'h1};
    src[PIN] <= 1'h1;
    ev(POR, 5);
    repeat (4500) @(posedge mclk);
    chk(33'(core_reset_n), 33'h0);
    src[PIN] <= 1'h0;
    wait_rst(1'h1, 4, n);
    wrap_up();
  end
endmodule : tb_top
bind rsc_reset_sequencer rsc_reset_sequencer_chk chk (.mclk, .rst_n, .clk_en, .cfg, .por_detect,
  .external_reset_pin_n, .watchdog_timeout, .core_ev, .core_reset_n, .core_hold, .wake_pulse, .paddr,
  .psel, .penable, .prdata, .pready, .pslverr);
`default_nettype wire
